/* File: src/cmmap_pkg.sv */
// cmmap_pkg: constants for the core memory map and special function registers
// assumes an 8-bit core issuing register and memory requests on clk_sys
package cmmap_pkg;
	// =====================================================================
	// register addresses
	localparam logic [7:0] ADDR_STACK = 8'h81;
	localparam logic [7:0] ADDR_DP0_LO = 8'h82;
	localparam logic [7:0] ADDR_DP0_HI = 8'h83;
	localparam logic [7:0] ADDR_DP1_LO = 8'h84;
	localparam logic [7:0] ADDR_DP1_HI = 8'h85;
	localparam logic [7:0] ADDR_PAGE = 8'h86;
	localparam logic [7:0] ADDR_IFCTL = 8'h8f;
	localparam logic [7:0] ADDR_ROUTE = 8'h91;
	localparam logic [7:0] ADDR_STATUS = 8'hd0;
	localparam logic [7:0] ADDR_MAIN = 8'he0;
	localparam logic [7:0] ADDR_SECOND = 8'hf0;
	// =====================================================================
	// reset values
	localparam logic [7:0] RST_STACK = 8'h07;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// =====================================================================
	// field positions
	localparam int BIT_CARRY = 7;
	localparam int BIT_HALF = 6;
	localparam int BIT_UF0 = 5;
	localparam int BIT_BANK_HI = 4;
	localparam int BIT_BANK_LO = 3;
	localparam int BIT_RANGE = 2;
	localparam int BIT_UF1 = 1;
	localparam int BIT_PARITY = 0;
	localparam int BIT_PTRSEL = 0;
	localparam int BIT_XDIS = 1;
	// writable masks of the mixed registers
	localparam logic [7:0] IFCTL_WMASK = 8'hbf;
	localparam logic [7:0] ROUTE_WMASK = 8'hbb;
	localparam logic [7:0] STATUS_WMASK = 8'hfe;
	// =====================================================================
	// memory map
	localparam logic [7:0] LOW_TOP = 8'h7f;
	localparam logic [7:0] BANK_TOP = 8'h1f;
	localparam logic [7:0] BITAREA_LO = 8'h20;
	localparam logic [7:0] BITAREA_HI = 8'h2f;
	localparam logic [15:0] XRAM_TOP = 16'h03ff;
	localparam logic [7:0] PAGE_TOP = 8'h03;
	localparam int XRAM_WORDS = 1024;
	localparam int XRAM_AW = 10;
	localparam logic [4:0] BOOT_MAX = 5'h10;
	// =====================================================================
	typedef enum logic [2:0] {
		CM_IDLE = 3'b001,
		CM_EXT = 3'b010,
		CM_DONE = 3'b100
	} cmmap_xstate_t;
endpackage

/* File: src/cmmap_xram.sv */
// cmmap_xram: 1 KB on-chip expanded data RAM
// assumes one access per cycle, read data valid one edge after request
`timescale 1ns/100ps
module cmmap_xram
	import cmmap_pkg::*;
(
	input wire logic clk_sys,
	input wire logic en,
	input wire logic we,
	input wire logic [XRAM_AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [XRAM_WORDS];

	// =====================================================================
	// storage
	always_ff @(posedge clk_sys)
	begin
		if (en && we)
		begin
			mem[addr] <= wdata;
		end
		if (en)
		begin
			rdata <= mem[addr];
		end
	end
endmodule // cmmap_xram

/* File: src/cmmap_core.sv */
// cmmap_core: core register file, internal data RAM and external-move routing
// assumes the instruction sequencer drives one request at a time
// Function
// RULE_01: program space 64 KB; top boot area of 256-byte blocks, count 0..16
// RULE_02: count zero gives no boot area; each block grows area downward
// RULE_03: internal locations 00H-7FH reachable directly and indirectly
// RULE_04: 00H-1FH register banks, 20H-2FH bit area, 30H-7FH general
// RULE_05: locations 80H-FFH reachable only indirectly, plain storage
// RULE_06: external moves at 0000H-03FFH go to on-chip expanded RAM
// RULE_07: pointer external moves above 03FFH drive external strobes
// RULE_08: register-indirect moves take high byte from page register
// RULE_09: enabled RAM and page 0..3 reach on-chip RAM
// RULE_10: enabled RAM and page 4..255 drive page onto high port
// RULE_11: disabled RAM ignores page; high byte from high port latch
// RULE_12: stack pointer resets 07H, increments before each push
// RULE_13: bank select maps working registers to 00H,08H,10H,18H
// RULE_14: parity bit keeps total ones with main operand even
// RULE_15: status word layout carry..parity, reset 00H
// RULE_16: second operand register partners multiply and divide
// RULE_17: routing register bit 0 selects active data pointer
// RULE_18: expanded RAM disable at interface control bit 1, reset 0
// RULE_19: on-chip RAM accesses leave strobes and high port alone
`timescale 1ns/100ps
module cmmap_core
	import cmmap_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [4:0] bootBlocks,
	input wire logic [15:0] fetchAddr,
	output logic fetchInBoot,
	output logic [15:0] bootBase,
	input wire logic sfrWe,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWdata,
	output logic [7:0] sfrRdata,
	output logic sfrHit,
	input wire logic iramReq,
	input wire logic iramWe,
	input wire logic iramIndirect,
	input wire logic [7:0] iramAddr,
	input wire logic [7:0] iramWdata,
	output logic [7:0] iramRdata,
	output logic iramRefused,
	input wire logic [2:0] regNum,
	output logic [7:0] regAddr,
	input wire logic pushReq,
	input wire logic [7:0] pushData,
	input wire logic popReq,
	output logic [7:0] popData,
	input wire logic aluWe,
	input wire logic [7:0] aluMain,
	input wire logic [7:0] aluSecond,
	input wire logic aluSecondWe,
	input wire logic [3:0] aluFlags,
	input wire logic ptrIncr,
	output logic [15:0] activePtr,
	input wire logic xmoveReq,
	input wire logic xmoveWe,
	input wire logic xmoveByPtr,
	input wire logic [7:0] xmoveLowAddr,
	input wire logic [7:0] xmoveWdata,
	output logic [7:0] xmoveRdata,
	output logic xmoveDone,
	input wire logic [7:0] highPortLatch,
	output logic [7:0] extAddrHigh,
	output logic [7:0] extAddrLow,
	output logic [7:0] extWdata,
	output logic extRdStrobe,
	output logic extWrStrobe,
	input wire logic [7:0] extRdata
);
	logic [7:0] stackReg, dp0LoReg, dp0HiReg, dp1LoReg, dp1HiReg, pageReg;
	logic [7:0] ifctlReg, routeReg, statusReg, mainReg, secondReg;
	logic [7:0] iram [256];
	logic [4:0] blk;
	logic parityNow, ptrSel, xramDisable;
	logic [15:0] xAddr;
	logic toXram, xramEn, xramRdPend;
	logic [7:0] xramQ;
	logic [7:0] stackNext;
	cmmap_xstate_t xState;

	// =====================================================================
	// program space partition
	always_comb
	begin
		blk = (bootBlocks > BOOT_MAX) ? BOOT_MAX : bootBlocks; // RULE_01
		bootBase = 16'(17'h1_0000 - {blk, 8'h00}); // RULE_02
		fetchInBoot = (blk != 5'h00) && (fetchAddr >= bootBase); // RULE_02
	end

	// =====================================================================
	// derived control
	assign parityNow = ^mainReg; // RULE_14
	assign ptrSel = routeReg[BIT_PTRSEL]; // RULE_17
	assign xramDisable = ifctlReg[BIT_XDIS]; // RULE_18
	assign activePtr = ptrSel ? {dp1HiReg, dp1LoReg} : {dp0HiReg, dp0LoReg};
	assign regAddr = {3'b000, statusReg[BIT_BANK_HI:BIT_BANK_LO], regNum}; // RULE_13
	assign stackNext = 8'(stackReg + 8'h01); // RULE_12

	// =====================================================================
	// register read
	always_comb
	begin
		sfrHit = 1'b1;
		case (sfrAddr)
			ADDR_STACK: sfrRdata = stackReg;
			ADDR_DP0_LO: sfrRdata = dp0LoReg;
			ADDR_DP0_HI: sfrRdata = dp0HiReg;
			ADDR_DP1_LO: sfrRdata = dp1LoReg;
			ADDR_DP1_HI: sfrRdata = dp1HiReg;
			ADDR_PAGE: sfrRdata = pageReg;
			ADDR_IFCTL: sfrRdata = ifctlReg;
			ADDR_ROUTE: sfrRdata = routeReg;
			ADDR_STATUS: sfrRdata = {statusReg[7:1], parityNow}; // RULE_15
			ADDR_MAIN: sfrRdata = mainReg;
			ADDR_SECOND: sfrRdata = secondReg; // RULE_16
			default:
			begin
				sfrRdata = RST_ZERO;
				sfrHit = 1'b0;
			end
		endcase
	end

	// =====================================================================
	// stack pointer
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			stackReg <= RST_STACK; // RULE_12
		else if (sfrWe && sfrAddr == ADDR_STACK)
			stackReg <= sfrWdata;
		else if (pushReq)
			stackReg <= stackNext; // RULE_12
		else if (popReq)
			stackReg <= 8'(stackReg - 8'h01);
	end

	// =====================================================================
	// data pointers
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			dp0LoReg <= RST_ZERO;
			dp0HiReg <= RST_ZERO;
			dp1LoReg <= RST_ZERO;
			dp1HiReg <= RST_ZERO;
		end
		else if (ptrIncr)
		begin
			if (ptrSel) // RULE_17
				{dp1HiReg, dp1LoReg} <= 16'({dp1HiReg, dp1LoReg} + 16'h0001);
			else
				{dp0HiReg, dp0LoReg} <= 16'({dp0HiReg, dp0LoReg} + 16'h0001);
		end
		else if (sfrWe)
		begin
			if (sfrAddr == ADDR_DP0_LO)
				dp0LoReg <= sfrWdata;
			if (sfrAddr == ADDR_DP0_HI)
				dp0HiReg <= sfrWdata;
			if (sfrAddr == ADDR_DP1_LO)
				dp1LoReg <= sfrWdata;
			if (sfrAddr == ADDR_DP1_HI)
				dp1HiReg <= sfrWdata;
		end
	end

	// =====================================================================
	// page, interface control and routing
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			pageReg <= RST_ZERO; // RULE_08
			ifctlReg <= RST_ZERO; // RULE_18
			routeReg <= RST_ZERO;
		end
		else if (sfrWe)
		begin
			if (sfrAddr == ADDR_PAGE)
				pageReg <= sfrWdata;
			if (sfrAddr == ADDR_IFCTL)
				ifctlReg <= sfrWdata & IFCTL_WMASK;
			if (sfrAddr == ADDR_ROUTE)
				routeReg <= sfrWdata & ROUTE_WMASK;
		end
	end

	// =====================================================================
	// status word, main and second operand
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			statusReg <= RST_ZERO; // RULE_15
		else if (sfrWe && sfrAddr == ADDR_STATUS)
			statusReg <= sfrWdata & STATUS_WMASK;
		else if (aluWe)
		begin
			statusReg[BIT_CARRY] <= aluFlags[3]; // RULE_15
			statusReg[BIT_HALF] <= aluFlags[2];
			statusReg[BIT_RANGE] <= aluFlags[1];
			statusReg[BIT_UF1] <= statusReg[BIT_UF1] | aluFlags[0];
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			mainReg <= RST_ZERO;
			secondReg <= RST_ZERO;
		end
		else if (sfrWe && (sfrAddr == ADDR_MAIN || sfrAddr == ADDR_SECOND))
		begin
			if (sfrAddr == ADDR_MAIN)
				mainReg <= sfrWdata;
			else
				secondReg <= sfrWdata; // RULE_16
		end
		else
		begin
			if (aluWe)
				mainReg <= aluMain;
			if (aluSecondWe)
				secondReg <= aluSecond; // RULE_16
		end
	end

	// =====================================================================
	// internal data RAM, stack traffic uses it too
	always_ff @(posedge clk_sys)
	begin
		if (pushReq)
			iram[stackNext] <= pushData; // RULE_12
		else if (iramReq && iramWe && !iramRefused)
			iram[iramAddr] <= iramWdata; // RULE_03 RULE_04 RULE_05
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			iramRdata <= RST_ZERO;
			popData <= RST_ZERO;
		end
		else
		begin
			if (iramReq && !iramWe && !iramRefused)
				iramRdata <= iram[iramAddr]; // RULE_03
			if (popReq)
				popData <= iram[stackReg];
		end
	end

	// direct addressing above 7FH belongs to the register space
	assign iramRefused = iramReq && !iramIndirect && (iramAddr > LOW_TOP); // RULE_05

	// =====================================================================
	// external move routing
	always_comb
	begin
		if (xmoveByPtr)
			xAddr = {activePtr[15:8], xmoveLowAddr}; // RULE_17
		else if (xramDisable)
			xAddr = {highPortLatch, xmoveLowAddr}; // RULE_11
		else
			xAddr = {pageReg, xmoveLowAddr}; // RULE_08
		toXram = !xramDisable && (xAddr <= XRAM_TOP); // RULE_06 RULE_09
		xramEn = xmoveReq && (xState == CM_IDLE) && toXram; // RULE_19
	end

	cmmap_xram u_xram (
		.clk_sys(clk_sys),
		.en(xramEn),
		.we(xmoveWe),
		.addr(xAddr[XRAM_AW-1:0]),
		.wdata(xmoveWdata),
		.rdata(xramQ)
	);

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			xState <= CM_IDLE;
			extAddrHigh <= RST_ZERO;
			extAddrLow <= RST_ZERO;
			extWdata <= RST_ZERO;
			extRdStrobe <= 1'b0;
			extWrStrobe <= 1'b0;
			xmoveRdata <= RST_ZERO;
			xmoveDone <= 1'b0;
			xramRdPend <= 1'b0;
		end
		else
		begin
			xmoveDone <= 1'b0;
			xramRdPend <= xramEn && !xmoveWe;
			if (xramRdPend)
				xmoveRdata <= xramQ;
			case (xState)
				CM_IDLE:
				begin
					if (xmoveReq && toXram)
						xState <= CM_DONE; // RULE_19
					else if (xmoveReq)
					begin
						extAddrHigh <= xAddr[15:8]; // RULE_07 RULE_10 RULE_11
						extAddrLow <= xAddr[7:0];
						extWdata <= xmoveWdata;
						extRdStrobe <= !xmoveWe; // RULE_07
						extWrStrobe <= xmoveWe;
						xState <= CM_EXT;
					end
				end
				CM_EXT:
				begin
					extRdStrobe <= 1'b0;
					extWrStrobe <= 1'b0;
					if (extRdStrobe)
						xmoveRdata <= extRdata;
					xState <= CM_DONE;
				end
				CM_DONE:
				begin
					xmoveDone <= 1'b1;
					xState <= CM_IDLE;
				end
				default: xState <= CM_IDLE;
			endcase
		end
	end
endmodule // cmmap_core

/* File: tb/cmmap_core_monitor.sv */
// cmmap_core_monitor: port assertions for cmmap_core
// assumes it is bound into cmmap_core
`timescale 1ns/100ps
module cmmap_core_monitor
	import cmmap_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [4:0] bootBlocks,
	input wire logic [15:0] fetchAddr,
	input wire logic fetchInBoot,
	input wire logic sfrWe,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWdata,
	input wire logic [7:0] sfrRdata,
	input wire logic iramReq,
	input wire logic iramIndirect,
	input wire logic [7:0] iramAddr,
	input wire logic iramRefused,
	input wire logic [2:0] regNum,
	input wire logic [7:0] regAddr,
	input wire logic pushReq,
	input wire logic popReq,
	input wire logic xmoveByPtr,
	input wire logic [7:0] xmoveLowAddr,
	input wire logic xmoveDone,
	input wire logic [15:0] activePtr,
	input wire logic [7:0] extAddrHigh,
	input wire logic [7:0] extAddrLow,
	input wire logic extRdStrobe,
	input wire logic extWrStrobe
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	logic strobe;
	assign strobe = extRdStrobe | extWrStrobe;
	// bank field as last written through the status word
	logic [1:0] bankSeen;
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			bankSeen <= 2'h0;
		else if (sfrWe && sfrAddr == ADDR_STATUS)
			bankSeen <= sfrWdata[BIT_BANK_HI:BIT_BANK_LO];
	end
	sequence s_push;
		pushReq && !popReq && !sfrWe && sfrAddr == ADDR_STACK;
	endsequence
	sequence s_ptr_ext;
		strobe && xmoveByPtr;
	endsequence
	// ==========
	// assertions
	a_boot_none: assert property (bootBlocks == 5'h00 |-> !fetchInBoot)
		else $error("boot flag with no blocks");
	a_boot_range: assert property (bootBlocks != 5'h00
		&& bootBlocks <= BOOT_MAX |-> fetchInBoot == ({1'b0, fetchAddr}
		>= 17'h1_0000 - {4'h0, bootBlocks, 8'h00}))
		else $error("boot flag wrong");
	a_direct_refuse: assert property (iramReq && !iramIndirect
		|-> iramRefused == (iramAddr > LOW_TOP))
		else $error("direct refusal wrong");
	a_bank_addr: assert property (regAddr
		== {3'h0, bankSeen, regNum})
		else $error("register address wrong");
	a_push_inc: assert property (s_push ##1 sfrAddr == ADDR_STACK
		|-> sfrRdata == $past(sfrRdata) + 8'h01)
		else $error("stack not incremented");
	a_ext_done: assert property (strobe |-> ##2 xmoveDone)
		else $error("external move not done");
	a_ptr_addr: assert property (s_ptr_ext |-> extAddrLow == xmoveLowAddr
		&& extAddrHigh == activePtr[15:8])
		else $error("pointer address wrong");
	a_strobe_one: assert property (strobe |=> !strobe)
		else $error("strobe too long");
	a_strobe_excl: assert property (!(extRdStrobe && extWrStrobe))
		else $error("both strobes");
endmodule // cmmap_core_monitor
bind cmmap_core cmmap_core_monitor i_cmmap_core_monitor (.clk_sys, .resetn,
	.bootBlocks, .fetchAddr, .fetchInBoot, .sfrWe, .sfrAddr, .sfrWdata,
	.sfrRdata,
	.iramReq, .iramIndirect, .iramAddr, .iramRefused, .regNum, .regAddr,
	.pushReq, .popReq, .xmoveByPtr, .xmoveLowAddr, .xmoveDone, .activePtr,
	.extAddrHigh, .extAddrLow, .extRdStrobe, .extWrStrobe);

/* File: tb/cmmap_ext_ram.sv */
// cmmap_ext_ram: external data RAM on the paged bus
// assumes single-cycle strobes on clk_sys
`timescale 1ns/100ps
module cmmap_ext_ram
(
	input wire logic clk_sys,
	input wire logic [7:0] extAddrHigh,
	input wire logic [7:0] extAddrLow,
	input wire logic [7:0] extWdata,
	input wire logic extRdStrobe,
	input wire logic extWrStrobe,
	output logic [7:0] extRdata
);
	logic [7:0] mem [65536];
	logic [7:0] lastRd = 8'h00;
	// released bus shows the inverse of the last value
	assign extRdata = extRdStrobe ? mem[{extAddrHigh, extAddrLow}] : ~lastRd;
	always @(posedge clk_sys)
	begin
		if (extWrStrobe)
			mem[{extAddrHigh, extAddrLow}] <= extWdata;
		if (extRdStrobe)
			lastRd <= extRdata;
	end
endmodule // cmmap_ext_ram

/* File: tb/testbench.sv */
// testbench: random and corner stimulus for cmmap_core
// assumes cmmap_ext_ram on the external bus
`timescale 1ns/100ps
module testbench;
	import cmmap_pkg::*;
	logic clk_sys = 1'b0, resetn = 1'b0, sfrWe = 0, iramReq = 0, iramWe = 0;
	logic iramIndirect = 0, pushReq = 0, popReq = 0, aluWe = 0;
	logic aluSecondWe = 0, ptrIncr = 0, xmoveReq = 0, xmoveWe = 0;
	logic xmoveByPtr = 0, saw, ext, fetchInBoot, sfrHit, iramRefused;
	logic xmoveDone, extRdStrobe, extWrStrobe;
	logic [4:0] bootBlocks = 0;
	logic [3:0] aluFlags = 0;
	logic [2:0] regNum = 0;
	logic [15:0] fetchAddr = 0, bootBase, activePtr, seed = 16'h6a86, p, e;
	logic [7:0] sfrAddr = 0, sfrWdata = 0, iramAddr = 0, iramWdata = 0;
	logic [7:0] pushData = 0, aluMain = 0, aluSecond = 0, xmoveLowAddr = 0;
	logic [7:0] xmoveWdata = 0, highPortLatch = 0, iramRdata, regAddr;
	logic [7:0] popData, xmoveRdata, extAddrHigh, extAddrLow, extWdata;
	logic [7:0] extRdata, sfrRdata, d, w, lo, hb;
	int errors = 0, total_checks = 0;
	logic [15:0] rt [11] = '{16'h81ff, 16'h82ff, 16'h83ff, 16'h84ff,
		16'h85ff, 16'h86ff, 16'h8fbf, 16'h91bb, 16'he0ff, 16'hd0fe, 16'hf0ff};
	logic [7:0] ia [5] = '{8'h1f, 8'h20, 8'h7f, 8'h80, 8'hff};
	logic [9:0] xt [8] = '{10'h003, 10'h004, 10'h0ff, 10'h000, 10'h102,
		10'h203, 10'h2f0, 10'h301};
	always #2.5 clk_sys = ~clk_sys;
	cmmap_core i_cmmap_core (.clk_sys, .resetn, .bootBlocks, .fetchAddr,
		.fetchInBoot, .bootBase, .sfrWe, .sfrAddr, .sfrWdata, .sfrRdata,
		.sfrHit, .iramReq, .iramWe, .iramIndirect, .iramAddr, .iramWdata,
		.iramRdata, .iramRefused, .regNum, .regAddr, .pushReq, .pushData,
		.popReq, .popData, .aluWe, .aluMain, .aluSecond, .aluSecondWe,
		.aluFlags, .ptrIncr, .activePtr, .xmoveReq, .xmoveWe, .xmoveByPtr,
		.xmoveLowAddr, .xmoveWdata, .xmoveRdata, .xmoveDone, .highPortLatch,
		.extAddrHigh, .extAddrLow, .extWdata, .extRdStrobe, .extWrStrobe,
		.extRdata);
	cmmap_ext_ram i_cmmap_ext_ram (.clk_sys, .extAddrHigh, .extAddrLow,
		.extWdata, .extRdStrobe, .extWrStrobe, .extRdata);
	// ==========
	// helpers
	function automatic logic [15:0] rnd();
		seed = seed ^ (seed << 7);
		seed = seed ^ (seed >> 9);
		seed = seed ^ (seed << 8);
		return seed;
	endfunction
	function automatic logic boot_exp(logic [4:0] n, logic [15:0] a);
		return n != 5'h00 && {1'b0, a} >= 17'h1_0000 - {4'h0, n, 8'h00};
	endfunction
	task automatic chk(string n, logic [15:0] x, logic [15:0] g);
		total_checks++;
		if (g !== x)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic sfr_wr(logic [7:0] a, logic [7:0] v);
		@(negedge clk_sys);
		sfrAddr = a;
		sfrWdata = v;
		sfrWe = 1'b1;
		@(negedge clk_sys);
		sfrWe = 1'b0;
	endtask
	task automatic sfr_rd(logic [7:0] a);
		@(negedge clk_sys);
		sfrAddr = a;
		#1 d = sfrRdata;
	endtask
	task automatic iram(logic we, logic ind, logic [7:0] a, logic [7:0] v);
		@(negedge clk_sys);
		iramWe = we;
		iramIndirect = ind;
		iramAddr = a;
		iramWdata = v;
		iramReq = 1'b1;
		#1 saw = iramRefused;
		@(negedge clk_sys);
		iramReq = 1'b0;
		d = iramRdata;
	endtask
	task automatic xm(logic we, logic ptr, logic [7:0] a, logic [7:0] v);
		@(negedge clk_sys);
		xmoveWe = we;
		xmoveByPtr = ptr;
		xmoveLowAddr = a;
		xmoveWdata = v;
		xmoveReq = 1'b1;
		saw = 1'b0;
		for (int k = 0; k < 8 && xmoveDone !== 1'b1; k++)
		begin
			@(negedge clk_sys);
			saw = saw | extRdStrobe | extWrStrobe;
		end
		xmoveReq = 1'b0;
		d = xmoveRdata;
	endtask
	initial
	begin
		#100000;
		errors++;
		complete_run();
	end
	// ==========
	// scenarios
	initial
	begin
		repeat (12) @(negedge clk_sys);
		resetn = 1'b1;
		for (int i = 0; i < 11; i++)
		begin
			sfr_rd(rt[i][15:8]);
			chk("rst", 16'(i ? 0 : 7), 16'(d));
		end
		for (int i = 0; i < 22; i++)
		begin
			w = 8'(rnd());
			sfr_wr(rt[i % 11][15:8], w);
			if (i % 11 == 8)
				hb = w;
			sfr_rd(rt[i % 11][15:8]);
			e = 16'(w & rt[i % 11][7:0] | 8'(i % 11 == 9 && ^hb));
			chk("sfr", e, 16'(d));
		end
		sfr_rd(8'h92);
		chk("unmapped", 16'h0000, {7'h00, sfrHit, d});
		sfr_wr(ADDR_STATUS, RST_ZERO);
		aluFlags = 4'(rnd());
		aluMain = 8'(rnd());
		aluSecond = ~aluMain;
		aluWe = 1'b1;
		aluSecondWe = 1'b1;
		@(negedge clk_sys);
		aluWe = 1'b0;
		aluSecondWe = 1'b0;
		sfr_rd(ADDR_SECOND);
		chk("second", 16'(aluSecond), 16'(d));
		sfr_rd(ADDR_STATUS);
		chk("parity", 16'(^aluMain), 16'(d[0]));
		e = 16'({aluFlags[3:2], 3'h0, aluFlags[1:0], ^aluMain});
		chk("status", e, 16'(d));
		for (int b = 0; b < 4; b++)
		begin
			sfr_wr(ADDR_STATUS, 8'(b << 3));
			regNum = 3'(rnd());
			#1 chk("bank", 16'(b * 8 + regNum), 16'(regAddr));
		end
		sfr_wr(ADDR_STACK, RST_STACK);
		@(negedge clk_sys);
		pushData = 8'(rnd());
		pushReq = 1'b1;
		@(negedge clk_sys);
		pushReq = 1'b0;
		sfr_rd(ADDR_STACK);
		chk("push sp", 16'h0008, 16'(d));
		iram(1'b0, 1'b1, 8'h08, 8'h00);
		chk("push data", 16'(pushData), 16'(d));
		popReq = 1'b1;
		@(negedge clk_sys);
		popReq = 1'b0;
		chk("pop", {pushData, 8'h07}, {popData, sfrRdata});
		foreach (ia[j])
		begin
			w = 8'(rnd());
			iram(1'b1, ia[j] > LOW_TOP, ia[j], w);
			iram(1'b0, 1'b0, ia[j], 8'h00);
			chk("refused", 16'(ia[j] > LOW_TOP), 16'(saw));
			iram(1'b0, 1'b1, ia[j], 8'h00);
			chk("iram", 16'(w), 16'(d));
		end
		for (int n = 0; n <= 16; n++)
			for (int k = 0; k < 3; k++)
			begin
				@(negedge clk_sys);
				bootBlocks = 5'(n);
				p = 16'(17'h1_0000 - n * 256);
				fetchAddr = k == 0 ? rnd() : p - 16'(k - 1);
				e = 16'(boot_exp(bootBlocks, fetchAddr));
				#1 chk("boot", e, 16'(fetchInBoot));
				if (n > 0)
					chk("base", p, bootBase);
			end
		sfr_wr(ADDR_ROUTE, 8'h01);
		foreach (xt[j])
		begin
			sfr_wr(ADDR_IFCTL, {6'h00, xt[j][8], 1'b0});
			sfr_wr(ADDR_PAGE, xt[j][7:0]);
			sfr_wr(ADDR_DP1_HI, xt[j][7:0]);
			sfr_wr(ADDR_DP0_HI, ~xt[j][7:0]);
			highPortLatch = 8'(rnd());
			{w, lo} = rnd();
			hb = extAddrHigh;
			ext = xt[j][8] || xt[j][7:0] > PAGE_TOP;
			if (ext)
				hb = xt[j][9:8] == 2'b01 ? highPortLatch : xt[j][7:0];
			xm(1'b1, xt[j][9], lo, w);
			chk("wr ext", 16'(ext), 16'(saw));
			xm(1'b0, xt[j][9], lo, 8'h00);
			chk("rd data", 16'(w), 16'(d));
			chk("high", {hb, 7'h00, ext}, {extAddrHigh, 7'h00, saw});
		end
		sfr_wr(ADDR_DP1_LO, 8'hff);
		sfr_wr(ADDR_DP0_LO, 8'hff);
		for (int s = 1; s >= 0; s--)
		begin
			sfr_wr(ADDR_ROUTE, 8'(s));
			ptrIncr = 1'b1;
			@(negedge clk_sys);
			ptrIncr = 1'b0;
			chk("ptr", s ? 16'h0200 : 16'hff00, activePtr);
		end
		complete_run();
	end
endmodule // testbench
